// >>> logic/dac_format_and_zero_flag_config.sv
// serial-loaded format, filter, phase and zero flag settings of the dac
//
// Overview of operation
// (RULE_01) Format 000-011 is 24/20/18/16-bit RJ, 100 I2S, 110/111 reserved.
// (RULE_02) Reset sets the format field to 101, left-justified 16 to 24 bits.
// (RULE_03) One rolloff bit picks sharp (0, reset) or slow (1) response.
// (RULE_04) Phase bit 0 (reset) keeps the output normal, 1 inverts it.
// (RULE_05) Flag polarity 0 (reset) shows a zero as high, 1 shows it as low.
// (RULE_06) Flag mode 0 (reset) gives separate left/right flags, 1 one flag.
// (RULE_07) Separate: pin1 right, pin2 left; common: pin1 both, pin2 unused.
// (RULE_08) The default modulator path runs at 64 times the sample rate.
// (RULE_09) The host writes zero to all reserved bits.
// (RULE_10) Writes are 16 bits, msb first: a zero, 7-bit index, 8 data bits.
// (RULE_11) Latch low, 16 shift clocks, latch high; its rise loads the data.
// (RULE_12) The polarity applies to every active flag pin in both modes.
`timescale 1ns/1ps
module dac_format_and_zero_flag_config
  import dac_cfg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic soft_reset,
  input wire logic control_shift_clock,
  input wire logic control_latch_line,
  input wire logic control_serial_input,
  input wire logic left_zero_detect,
  input wire logic right_zero_detect,
  output dac_cfg_pkg::audio_fmt_t audio_word_format_sel,
  output logic rolloff_select,
  output logic phase_invert,
  output logic zero_flag_polarity,
  output logic zero_flag_mode,
  output logic [7:0] mod_oversample_ratio,
  output logic zero_flag_pin1,
  output logic zero_flag_pin2
);
  import dac_cfg_pkg::*;

  function automatic logic idx_hit(input logic [15:0] word,
                                   input logic [6:0] idx);
    idx_hit = (word[IDX_LSB +: 7] == idx);
  endfunction : idx_hit

  ctrl_pins_t pins_raw;
  ctrl_pins_t pins_s;
  logic sclk_prev_r;
  logic sclk_prev_nxt;
  logic latch_prev_r;
  logic latch_prev_nxt;
  frame_state_t state_r;
  frame_state_t state_nxt;
  logic [15:0] sreg_r;
  logic [15:0] sreg_nxt;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  dac_cfg_t cfg_r;
  dac_cfg_t cfg_nxt;
  logic pin1_r;
  logic pin1_nxt;
  logic pin2_r;
  logic pin2_nxt;
  logic sclk_rise;
  logic latch_rise;
  logic frame_ok;
  logic wr_fmt;
  logic wr_zero;

  assign pins_raw = '{shift_clk: control_shift_clock,
    latch: control_latch_line, data: control_serial_input};

  pin_sync #(.WIDTH(3)) u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  assign sclk_rise = pins_s.shift_clk & ~sclk_prev_r;
  assign latch_rise = pins_s.latch & ~latch_prev_r;
  // only a full word with a zero lead bit is accepted
  assign frame_ok = (cnt_r == FRAME_BITS) && !sreg_r[FRAME_MSB]; // RULE_10

  always_comb begin
    sclk_prev_nxt = pins_s.shift_clk;
    latch_prev_nxt = pins_s.latch;
    state_nxt = state_r;
    sreg_nxt = sreg_r;
    cnt_nxt = cnt_r;
    cfg_nxt = cfg_r;
    wr_fmt = 1'b0;
    wr_zero = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (!pins_s.latch) begin // RULE_11
          state_nxt = ST_SHIFT;
          cnt_nxt = 5'h00;
        end
      end
      ST_SHIFT: begin
        // extra clocks beyond sixteen are dropped, the word stays intact
        if (sclk_rise && cnt_r != FRAME_BITS) begin
          sreg_nxt = {sreg_r[14:0], pins_s.data}; // RULE_10
          cnt_nxt = cnt_r + 5'h01;
        end
        if (latch_rise) begin
          state_nxt = ST_IDLE; // RULE_11
          wr_fmt = frame_ok && idx_hit(sreg_r, IDX_FORMAT_FILTER);
          wr_zero = frame_ok && idx_hit(sreg_r, IDX_PHASE_ZERO);
        end
      end
    endcase
    if (wr_fmt) begin
      cfg_nxt.rolloff = sreg_r[ROLLOFF_BIT]; // RULE_03
      // reserved codes would leave the audio port undefined, keep old one
      if (sreg_r[FMT_LSB + 2 -: 2] != 2'b11) begin
        cfg_nxt.fmt = audio_fmt_t'(sreg_r[FMT_LSB +: 3]); // RULE_01
      end
    end
    if (wr_zero) begin
      cfg_nxt.phase_inv = sreg_r[PHASE_BIT]; // RULE_04
      cfg_nxt.zpol = sreg_r[ZPOL_BIT]; // RULE_05
      cfg_nxt.zmode = sreg_r[ZMODE_BIT]; // RULE_06
    end
    if (soft_reset) begin
      cfg_nxt = CFG_RESET; // RULE_02
      state_nxt = ST_IDLE;
    end
    // combined flag means both channels are at zero
    if (cfg_r.zmode) begin // RULE_07
      pin1_nxt = (left_zero_detect & right_zero_detect) ^ cfg_r.zpol; // RULE_12
      pin2_nxt = cfg_r.zpol;
    end else begin
      pin1_nxt = right_zero_detect ^ cfg_r.zpol; // RULE_12
      pin2_nxt = left_zero_detect ^ cfg_r.zpol; // RULE_07
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sclk_prev_r <= 1'b1;
      latch_prev_r <= 1'b1;
      state_r <= ST_IDLE;
      sreg_r <= 16'h0000;
      cnt_r <= 5'h00;
      cfg_r <= CFG_RESET; // RULE_02
      pin1_r <= 1'b0;
      pin2_r <= 1'b0;
    end else begin
      sclk_prev_r <= sclk_prev_nxt;
      latch_prev_r <= latch_prev_nxt;
      state_r <= state_nxt;
      sreg_r <= sreg_nxt;
      cnt_r <= cnt_nxt;
      cfg_r <= cfg_nxt;
      pin1_r <= pin1_nxt;
      pin2_r <= pin2_nxt;
    end
  end

  assign audio_word_format_sel = cfg_r.fmt;
  assign rolloff_select = cfg_r.rolloff;
  assign phase_invert = cfg_r.phase_inv;
  assign zero_flag_polarity = cfg_r.zpol;
  assign zero_flag_mode = cfg_r.zmode;
  // fixed rate, the oversampling control sits in another bank
  assign mod_oversample_ratio = MOD_OSR; // RULE_08
  assign zero_flag_pin1 = pin1_r;
  assign zero_flag_pin2 = pin2_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_reset_defaults: assert property ($past(reset) |-> // RULE_02
    cfg_r == CFG_RESET) else $error("defaults not loaded after reset");
  a_fmt_write: assert property (wr_fmt && !soft_reset && // RULE_01
    sreg_r[2:1] != 2'b11 |=> cfg_r.fmt == $past(sreg_r[2:0]))
    else $error("format field not loaded");
  a_fmt_no_rsv: assert property (cfg_r.fmt != FMT_RSV6 && // RULE_01
    cfg_r.fmt != FMT_RSV7) else $error("reserved format held");
  a_rolloff_write: assert property (wr_fmt && !soft_reset |=> // RULE_03
    rolloff_select == $past(sreg_r[ROLLOFF_BIT]))
    else $error("rolloff bit not loaded");
  a_zero_write: assert property (wr_zero && !soft_reset |=> // RULE_04
    {zero_flag_mode, zero_flag_polarity, phase_invert} ==
    $past(sreg_r[2:0])) else $error("phase or flag bits not loaded");
  a_short_frame: assert property (latch_rise && // RULE_11
    cnt_r != FRAME_BITS && !soft_reset |=> $stable(cfg_r))
    else $error("short frame changed config");
  a_lead_one: assert property (latch_rise && sreg_r[FRAME_MSB] && // RULE_10
    !soft_reset |=> $stable(cfg_r)) else $error("frame with lead one taken");
  a_sep_flags: assert property (!cfg_r.zmode |=> // RULE_07
    zero_flag_pin1 == ($past(right_zero_detect) ^ $past(cfg_r.zpol)) &&
    zero_flag_pin2 == ($past(left_zero_detect) ^ $past(cfg_r.zpol)))
    else $error("separate flags misrouted");
  a_common_flag: assert property (cfg_r.zmode |=> // RULE_12
    zero_flag_pin1 == (($past(left_zero_detect) & $past(right_zero_detect))
    ^ $past(cfg_r.zpol)) && zero_flag_pin2 == $past(cfg_r.zpol))
    else $error("common flag wrong");
  a_osr_fixed: assert property (mod_oversample_ratio == 8'h40) // RULE_08
    else $error("modulator rate not 64");
  a_soft_defaults: assert property (soft_reset |=> // RULE_02
    cfg_r == CFG_RESET) else $error("soft reset left settings");
  // a reserved code must not reach the audio port, rolloff may still move
  a_fmt_rsv_kept: assert property (wr_fmt && !soft_reset && // RULE_01
    sreg_r[2:1] == 2'b11 |=> $stable(cfg_r.fmt))
    else $error("reserved format code taken");
  a_bad_index: assert property (latch_rise && !soft_reset && // RULE_10
    !idx_hit(sreg_r, IDX_FORMAT_FILTER) && !idx_hit(sreg_r, IDX_PHASE_ZERO)
    |=> $stable(cfg_r)) else $error("foreign index changed config");
  a_count_cap: assert property (cnt_r <= FRAME_BITS) // RULE_11
    else $error("bit count past sixteen");
  a_frame_start: assert property (state_r == ST_IDLE && // RULE_11
    !pins_s.latch && !soft_reset |=> state_r == ST_SHIFT && cnt_r == 5'h00)
    else $error("frame start missed");
  a_shift_count: assert property (sclk_rise && // RULE_10
    state_r == ST_SHIFT && cnt_r != FRAME_BITS |=>
    cnt_r == $past(cnt_r) + 5'h01) else $error("shift edge not counted");

  c_fmt_write: cover property (wr_fmt ##1 audio_word_format_sel == FMT_I2S);
  c_zero_write: cover property (wr_zero ##1 zero_flag_mode);
  c_soft_reset: cover property (soft_reset ##1 cfg_r == CFG_RESET);
  c_rsv_fmt: cover property (wr_fmt && sreg_r[2:1] == 2'b11);
  c_common_zero: cover property (cfg_r.zmode && pin1_r != cfg_r.zpol);
endmodule : dac_format_and_zero_flag_config

// >>> logic/dac_cfg_pkg.sv
// constants and types for the dac format and zero flag configuration bank
package dac_cfg_pkg;
  localparam logic [6:0] IDX_FORMAT_FILTER = 7'h14;
  localparam logic [6:0] IDX_PHASE_ZERO = 7'h16;
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam int FRAME_MSB = 15;
  localparam int IDX_LSB = 8;
  localparam int FMT_LSB = 0;
  localparam int ROLLOFF_BIT = 5;
  localparam int PHASE_BIT = 0;
  localparam int ZPOL_BIT = 1;
  localparam int ZMODE_BIT = 2;
  localparam logic [7:0] MOD_OSR = 8'h40;

  typedef enum logic [2:0] {
    FMT_RJ24 = 3'b000,
    FMT_RJ20 = 3'b001,
    FMT_RJ18 = 3'b010,
    FMT_RJ16 = 3'b011,
    FMT_I2S = 3'b100,
    FMT_LJ = 3'b101,
    FMT_RSV6 = 3'b110,
    FMT_RSV7 = 3'b111
  } audio_fmt_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_SHIFT = 1'b1
  } frame_state_t;

  typedef struct packed {
    audio_fmt_t fmt;
    logic rolloff;
    logic phase_inv;
    logic zpol;
    logic zmode;
  } dac_cfg_t;

  typedef struct packed {
    logic shift_clk;
    logic latch;
    logic data;
  } ctrl_pins_t;

  localparam audio_fmt_t FMT_RESET = FMT_LJ;
  localparam logic ROLLOFF_RESET = 1'b0;
  localparam logic PHASE_RESET = 1'b0;
  localparam logic ZPOL_RESET = 1'b0;
  localparam logic ZMODE_RESET = 1'b0;
  localparam dac_cfg_t CFG_RESET = '{fmt: FMT_RESET, rolloff: ROLLOFF_RESET,
    phase_inv: PHASE_RESET, zpol: ZPOL_RESET, zmode: ZMODE_RESET};
endpackage : dac_cfg_pkg

// >>> logic/pin_sync.sv
// two flip-flop synchroniser for the control port pins
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 3
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] stable_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      // the idle latch line sits high, so reset to high avoids a false edge
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          meta_r[i] <= 1'b1;
          stable_r[i] <= 1'b1;
        end else begin
          meta_r[i] <= async_in[i];
          stable_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  assign sync_out = stable_r;
endmodule : pin_sync

// >>> verification/ctrl_host.sv
// host model driving the three-wire control port
`timescale 1ns/1ps
module ctrl_host (
  input wire logic sys_clk,
  output logic control_shift_clock,
  output logic control_latch_line,
  output logic control_serial_input
);
  initial begin
    control_shift_clock = 1'b0;
    control_latch_line = 1'b1;
    control_serial_input = 1'b0;
  end
  // 4 cycles a level, above the 2 the synchroniser needs
  task automatic hold();
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : hold
  task automatic send(input logic lead, input logic [6:0] idx,
      input logic [7:0] dat, input int n);
    logic [15:0] w;
    w = {lead, idx, dat};
    control_latch_line = 1'b0;
    hold();
    for (int i = 0; i < n; i++) begin
      control_serial_input = (i < 16) ? w[15 - i] : ~w[0];
      hold();
      control_shift_clock = 1'b1;
      hold();
      control_shift_clock = 1'b0;
    end
    hold();
    control_latch_line = 1'b1;
    // released line must not keep the last bit
    control_serial_input = ~control_serial_input;
    repeat (6) hold();
  endtask : send
endmodule : ctrl_host

// >>> verification/testbench.sv
// self-checking bench for the dac format and zero flag bank
`timescale 1ns/1ps
module testbench;
  import dac_cfg_pkg::*;
  logic sys_clk, reset, soft_reset, lz, rz, sck, lat, sd, p1, p2;
  logic rolloff, phase, zpol, zmode, watching;
  audio_fmt_t fmt;
  logic [7:0] ratio;
  logic [31:0] rng;
  dac_cfg_t exp_cfg, seen, prev, n;
  dac_cfg_t notes[$];
  int fail_count, checked;
  ctrl_host host (.sys_clk(sys_clk), .control_shift_clock(sck),
    .control_latch_line(lat), .control_serial_input(sd));
  dac_format_and_zero_flag_config DUT (.sys_clk(sys_clk), .reset(reset),
    .soft_reset(soft_reset), .control_shift_clock(sck),
    .control_latch_line(lat), .control_serial_input(sd),
    .left_zero_detect(lz), .right_zero_detect(rz),
    .audio_word_format_sel(fmt), .rolloff_select(rolloff),
    .phase_invert(phase), .zero_flag_polarity(zpol),
    .zero_flag_mode(zmode), .mod_oversample_ratio(ratio),
    .zero_flag_pin1(p1), .zero_flag_pin2(p2));
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction : xorshift
  task automatic check(input string nm, input logic [7:0] s,
      input logic [7:0] e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : check
  task automatic final_report();
    if (fail_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  // note goes in before the frame, the change lands when the latch rises at its end
  task automatic note_cfg(input dac_cfg_t c);
    if (c !== exp_cfg) notes.push_back(c);
    exp_cfg = c;
  endtask : note_cfg
  task automatic flags();
    logic e1;
    logic e2;
    rng = xorshift(rng);
    lz = rng[0];
    rz = rng[1];
    e1 = exp_cfg.zmode ? (lz & rz) ^ exp_cfg.zpol : rz ^ exp_cfg.zpol;
    e2 = exp_cfg.zmode ? exp_cfg.zpol : lz ^ exp_cfg.zpol;
    repeat (3) @(posedge sys_clk);
    #1;
    check("pin1", p1, e1);
    check("pin2", p2, e2);
  endtask : flags
  always @(posedge sys_clk) begin
    #2;
    seen = {fmt, rolloff, phase, zpol, zmode};
    if (watching && seen !== prev) begin
      if (notes.size() == 0)
        check("unexpected cfg", 8'(seen), 8'hFF);
      else
        check("cfg", 8'(seen), 8'(notes.pop_front()));
    end
    prev = seen;
  end
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    #100000;
    fail_count++;
    final_report();
  end
  initial begin
    {reset, soft_reset, lz, rz, watching} = 5'h10;
    rng = 32'h43;
    fail_count = 0;
    checked = 0;
    exp_cfg = CFG_RESET;
    repeat (16) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    watching = 1'b1;
    check("defaults", 8'(seen), 8'(CFG_RESET));
    check("ratio", ratio, 8'h40);
    flags();
    for (int c = 0; c < 8; c++) begin
      rng = xorshift(rng);
      n = exp_cfg;
      n.rolloff = rng[0];
      // reserved codes leave the format as it was
      if (c < 6) n.fmt = audio_fmt_t'(c);
      note_cfg(n);
      host.send(1'b0, IDX_FORMAT_FILTER, {2'h0, rng[0], 2'h0, 3'(c)},
        16);
    end
    for (int c = 0; c < 8; c++) begin
      n = exp_cfg;
      {n.zmode, n.zpol, n.phase_inv} = 3'(c);
      note_cfg(n);
      host.send(1'b0, IDX_PHASE_ZERO, {5'h00, 3'(c)}, 16);
      repeat (4) flags();
    end
    host.send(1'b1, IDX_FORMAT_FILTER, 8'h00, 16);
    host.send(1'b0, 7'h15, 8'h00, 16);
    host.send(1'b0, IDX_FORMAT_FILTER, 8'h00, 15);
    // clocks past the sixteenth are dropped, the word stays intact
    n = exp_cfg;
    {n.zmode, n.zpol, n.phase_inv} = 3'b010;
    note_cfg(n);
    host.send(1'b0, IDX_PHASE_ZERO, 8'h02, 17);
    flags();
    note_cfg(CFG_RESET);
    soft_reset = 1'b1;
    @(posedge sys_clk);
    #1;
    soft_reset = 1'b0;
    repeat (2) flags();
    check("pending", 8'(notes.size()), 8'h00);
    final_report();
  end
endmodule : testbench
